// ### core/mex_pkg.sv
// Constants, types and field layouts for the memory exchange error
// and global scan block. Assumes a single 100 MHz synchronous domain.
package mex_pkg;
  localparam int DATA_W = 52;
  localparam int WORD_W = 60;
  localparam int HAM_W = 6;
  localparam int ADDR_W = 19;
  localparam int SCAN_W = 48;
  localparam int OVP_BIT = 58;
  localparam int SPARE_BIT = 59;
  localparam int OP_LSB = 42;
  localparam int OP_W = 6;
  localparam int VAR_LSB = 40;
  localparam int VAR_W = 2;
  localparam int SDATA_LSB = 16;
  localparam int SDATA_W = 24;
  localparam int RB_UNSUCC = 0;
  localparam int RB_INVALID = 1;
  localparam int RB_TXPAR = 2;
  localparam int RB_RCVD = 3;
  localparam int RB_STATE_LSB = 4;
  localparam int RB_RX_MSG_PAR = 4;
  localparam int RB_FLAG_LSB = 12;
  localparam logic [SCAN_W-1:0] RSP_BUF_RST = 48'h0;
  localparam logic [SCAN_W-1:0] MSG_BUF_RST = 48'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_MEM = 5'b00010,
    ST_CORR = 5'b00100,
    ST_SCAN = 5'b01000,
    ST_DONE = 5'b10000
  } mex_state_t;

  typedef struct packed {
    logic global_port;
    logic scan;
    logic write;
    logic scan_in;
    logic sel_msg;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mex_req_t;
endpackage

// ### core/mex_core.sv
// Memory exchange error handling and global scan port control.
// Assumes storage module and global module logic share clk.
// Summary of operation
// - Writes append 7 check bits and a zero spare bit, 60 stored
// - Reads correct any single bit error
// - Double-bit errors flagged, never corrected
// - Report single and multiple errors for logging
// - Address/control parity error repeats whole cycle
// - Successful retry is reported, operation completes
// - Second address/control error aborts, raises alarm
// - Read parity error gets read latches resent
// - Resent data bad starts correction cycle
// - Write data parity errors never retried
// - At most one retry per operation
// - Global memory and scan never overlap
// - Global port addresses 512K words like local
// - Scan-in reads response or message buffer
// - Scan-out always loads the response buffer
// - Arriving scan message with good parity interrupts the processor
// - Receiver writes result word to sender
// - Opcode 47:6, variant 41:2, data 39:24
// - Decode 32 functions in five classes
// - Normal response bits 4-11 give receiver state
// - Common bits 0-3 and 12-15 in both formats
// - Error response bits 4-8 parity flags, 9-11 zero
// - Scan flag picks scan versus global memory
// - Bad message parity gives error response
// - Sender owns control bus until response
`timescale 1ns/1ns
`default_nettype none
module mex_core
  import mex_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire mex_req_t req,
  output logic req_ready_q,
  output logic rsp_valid_q,
  output logic [DATA_W-1:0] rsp_data_q,
  output logic rsp_abort_q,
  output logic [SCAN_W-1:0] scan_rdata_q,
  output logic ev_single_q,
  output logic ev_multi_q,
  output logic ev_retry_q,
  output logic ev_alarm_q,
  output logic mem_req_q,
  output logic mem_write_q,
  output logic mem_global_q,
  output logic [ADDR_W-1:0] mem_addr_q,
  output logic [WORD_W-1:0] mem_wdata_q,
  output logic mem_resend_q,
  output logic mem_corr_q,
  input wire logic mem_done,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_acpar_err,
  input wire logic mem_rdpar_err,
  output logic scan_tx_valid_q,
  output logic [SCAN_W-1:0] scan_tx_word_q,
  output logic scan_bus_own_q,
  output logic scan_busy_q,
  input wire logic rsp_in_valid,
  input wire logic [SCAN_W-1:0] rsp_in_word,
  input wire logic msg_valid,
  input wire logic [SCAN_W-1:0] msg_word,
  input wire logic msg_par_err,
  input wire logic [4:0] msg_par_flags,
  input wire logic [7:0] rx_state,
  input wire logic [3:0] rx_flags,
  output logic msg_irq_q,
  output logic resp_out_valid_q,
  output logic [SCAN_W-1:0] resp_out_word_q
);
  // Hamming syndrome: data bit i sits at the i-th non power-of-two position
  function automatic logic [HAM_W-1:0] ham_syn(input logic [DATA_W-1:0] d);
    logic [HAM_W-1:0] s;
    logic [6:0] p;
    s = '0;
    p = 7'h03;
    for (int i = 0; i < DATA_W; i++) begin
      if ((p & (p - 7'h01)) == 7'h00) begin
        p = p + 7'h01;
      end
      if (d[i]) begin
        s = s ^ p[HAM_W-1:0];
      end
      p = p + 7'h01;
    end
    return s;
  endfunction
  function automatic logic [DATA_W-1:0] ham_fix(input logic [DATA_W-1:0] d,
                                                 input logic [HAM_W-1:0] s);
    logic [DATA_W-1:0] r;
    logic [6:0] p;
    r = d;
    p = 7'h03;
    for (int i = 0; i < DATA_W; i++) begin
      if ((p & (p - 7'h01)) == 7'h00) begin
        p = p + 7'h01;
      end
      if (p[HAM_W-1:0] == s) begin
        r[i] = ~d[i];
      end
      p = p + 7'h01;
    end
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] ecc_word(input logic [DATA_W-1:0] d);
    logic [HAM_W-1:0] s;
    s = ham_syn(d);
    return {1'b0, (^d) ^ (^s), s, d};
  endfunction

  // Unlisted opcodes (111011, 110100, 110101 and others) fall outside all classes
  function automatic logic op_known(input logic [OP_W-1:0] op);
    return (op >= 6'h01 && op <= 6'h07) || (op >= 6'h38 && op <= 6'h3d && op != 6'h3b)
        || (op >= 6'h10 && op <= 6'h17) || (op >= 6'h09 && op <= 6'h0e)
        || (op >= 6'h30 && op <= 6'h37 && op != 6'h34 && op != 6'h35);
  endfunction

  mex_state_t state_q, state_d;
  logic retry_q;
  logic [SCAN_W-1:0] rsp_buf_q;
  logic [SCAN_W-1:0] msg_buf_q;

  // Read check: syndrome plus overall parity over the stored word
  wire logic [HAM_W-1:0] rd_syn = ham_syn(mem_rdata[DATA_W-1:0])
                                  ^ mem_rdata[DATA_W+HAM_W-1:DATA_W];
  wire logic rd_ovp = ^mem_rdata[OVP_BIT:0];
  wire logic rd_single = rd_ovp;
  wire logic rd_multi = !rd_ovp && (rd_syn != '0);
  wire logic [DATA_W-1:0] rd_fixed = (rd_single && rd_syn != '0)
      ? ham_fix(mem_rdata[DATA_W-1:0], rd_syn) : mem_rdata[DATA_W-1:0];

  wire logic idle = (state_q == ST_IDLE);
  wire logic take = idle && req_valid;
  wire logic take_scan = take && req.global_port && req.scan;
  wire logic take_mem = take && !take_scan;
  wire logic scan_out_go = take_scan && !req.scan_in;
  wire logic scan_in_go = take_scan && req.scan_in;
  wire logic [SCAN_W-1:0] scan_src = req.sel_msg ? msg_buf_q : rsp_buf_q;
  wire logic fin = (state_q == ST_MEM || state_q == ST_CORR) && mem_done;
  wire logic ac_err = (state_q == ST_MEM) && mem_done && mem_acpar_err;
  wire logic ac_retry = ac_err && !retry_q;
  wire logic ac_abort = ac_err && retry_q;
  wire logic rd_err = (state_q == ST_MEM) && mem_done && !mem_write_q
                      && !mem_acpar_err && mem_rdpar_err;
  wire logic rd_retry = rd_err && !retry_q;
  wire logic rd_corr = rd_err && retry_q;
  // Write data parity has no input here: writes never retry for it
  wire logic deliver = fin && !ac_err && !rd_err;
  wire logic scan_back = (state_q == ST_SCAN) && rsp_in_valid;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (scan_out_go) begin
          state_d = ST_SCAN;
        end else if (scan_in_go) begin
          state_d = ST_DONE;
        end else if (take_mem) begin
          state_d = ST_MEM;
        end
      end
      ST_MEM: begin
        if (ac_abort || deliver) begin
          state_d = ST_DONE;
        end else if (rd_corr) begin
          state_d = ST_CORR;
        end
      end
      ST_CORR: begin
        if (mem_done) begin
          state_d = ST_DONE;
        end
      end
      ST_SCAN: begin
        if (rsp_in_valid) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // One FSM serialises global memory and scan use of the port
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      req_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_ready_q <= (state_d == ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      retry_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_write_q <= 1'b0;
      mem_global_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
      mem_resend_q <= 1'b0;
      mem_corr_q <= 1'b0;
    end else begin
      mem_req_q <= take_mem || ac_retry;
      mem_resend_q <= rd_retry;
      mem_corr_q <= rd_corr;
      if (take_mem) begin
        retry_q <= 1'b0;
        mem_write_q <= req.write;
        mem_global_q <= req.global_port;
        mem_addr_q <= req.addr;
        mem_wdata_q <= ecc_word(req.wdata);
      end else if (ac_retry || rd_retry) begin
        retry_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_abort_q <= 1'b0;
      ev_single_q <= 1'b0;
      ev_multi_q <= 1'b0;
      ev_retry_q <= 1'b0;
      ev_alarm_q <= 1'b0;
    end else begin
      rsp_valid_q <= fin && !ac_retry && !rd_err || ac_abort || scan_in_go || scan_back;
      rsp_abort_q <= ac_abort;
      ev_alarm_q <= ac_abort;
      ev_retry_q <= deliver && retry_q && state_q == ST_MEM;
      ev_single_q <= fin && !ac_err && !rd_err && !mem_write_q && rd_single;
      ev_multi_q <= fin && !ac_err && !rd_err && !mem_write_q && rd_multi;
      if (fin && !mem_write_q) begin
        rsp_data_q <= rd_fixed;
      end
    end
  end

  // Scan side: our response buffer, bus ownership and busy
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_buf_q <= RSP_BUF_RST;
      scan_rdata_q <= '0;
      scan_tx_valid_q <= 1'b0;
      scan_tx_word_q <= '0;
      scan_bus_own_q <= 1'b0;
      scan_busy_q <= 1'b0;
    end else begin
      scan_tx_valid_q <= scan_out_go;
      if (scan_out_go) begin
        rsp_buf_q <= req.wdata[SCAN_W-1:0];
        scan_tx_word_q <= req.wdata[SCAN_W-1:0];
        scan_bus_own_q <= 1'b1;
        scan_busy_q <= 1'b1;
      end else if (scan_back) begin
        rsp_buf_q <= rsp_in_word;
        scan_rdata_q <= rsp_in_word;
        scan_bus_own_q <= 1'b0;
        scan_busy_q <= 1'b0;
      end
      if (scan_in_go) begin
        scan_rdata_q <= scan_src;
      end
    end
  end

  // Receiver side: message buffer, interrupt, result word to sender
  wire logic [OP_W-1:0] msg_op = msg_word[OP_LSB+OP_W-1:OP_LSB];
  wire logic [15:0] resp_ok = {rx_flags, rx_state, 1'b1, 1'b0,
                               !op_known(msg_op), 1'b0};
  wire logic [15:0] resp_bad = {rx_flags, 3'b000, msg_par_flags, 1'b1, 1'b1,
                                1'b0, 1'b1};

  always_ff @(posedge clk) begin
    if (reset) begin
      msg_buf_q <= MSG_BUF_RST;
      msg_irq_q <= 1'b0;
      resp_out_valid_q <= 1'b0;
      resp_out_word_q <= '0;
    end else begin
      msg_irq_q <= msg_valid && !msg_par_err;
      resp_out_valid_q <= msg_valid;
      if (msg_valid) begin
        msg_buf_q <= msg_word;
        // Parity error: opcode ignored, error format returned
        resp_out_word_q <= {32'h0, msg_par_err ? resp_bad : resp_ok};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_first_ac_err;
    ac_err && !retry_q;
  endsequence
  sequence s_reissue;
    mem_req_q && retry_q && !rsp_valid_q;
  endsequence
  a_ac_retry_once: assert property (s_first_ac_err |=> s_reissue)
    else $error("address/control error did not reissue cycle");
  a_ac_abort_alarm: assert property (ac_err && retry_q |=> rsp_abort_q && ev_alarm_q
      ##1 state_q == ST_IDLE)
    else $error("second address/control error did not abort");
  a_rd_resend: assert property (rd_err && !retry_q |=> mem_resend_q && !mem_req_q)
    else $error("read parity error did not resend latches");
  a_rd_corr: assert property (rd_err && retry_q |=> mem_corr_q && state_q == ST_CORR)
    else $error("second read parity error did not start correction");
  a_wr_ecc: assert property (mem_req_q && mem_write_q |->
      mem_wdata_q[DATA_W+HAM_W-1:DATA_W] == ham_syn(mem_wdata_q[DATA_W-1:0])
      && !mem_wdata_q[SPARE_BIT] && !(^mem_wdata_q[OVP_BIT:0]))
    else $error("write check bits wrong");
  a_no_overlap: assert property (scan_busy_q |-> !mem_req_q && !mem_resend_q)
    else $error("memory cycle overlaps scan");
  a_scan_in_src: assert property (scan_in_go |=>
      rsp_valid_q && scan_rdata_q == $past(scan_src))
    else $error("scan-in returned wrong buffer");
  a_scan_busy_hold: assert property (scan_out_go |=> scan_busy_q && scan_bus_own_q
      throughout (state_q == ST_SCAN))
    else $error("busy or bus ownership dropped early");
  a_msg_irq: assert property (msg_valid && !msg_par_err |=> msg_irq_q && resp_out_valid_q)
    else $error("message arrival not signalled");
  a_err_format: assert property (msg_valid && msg_par_err |=> resp_out_valid_q
      && resp_out_word_q[RB_UNSUCC] && resp_out_word_q[RB_TXPAR]
      && resp_out_word_q[11:9] == 3'b000)
    else $error("error response format wrong");
  a_retry_report: assert property (deliver && retry_q && state_q == ST_MEM |=>
      ev_retry_q && rsp_valid_q)
    else $error("successful retry not reported");
endmodule
`default_nettype wire

// ### sim/mex_far_model.sv
// Storage module and far global module model for the exchange.
// Assumes one clock shared with mex_core; errors are armed by the bench.
`timescale 1ns/1ns
`default_nettype none
module mex_far_model
  import mex_pkg::*;
#(parameter int LAT = 2)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic arm,
  input wire logic [1:0] ac_errs,
  input wire logic [1:0] rd_errs,
  input wire logic [WORD_W-1:0] flip,
  input wire logic mem_req_q,
  input wire logic mem_write_q,
  input wire logic [ADDR_W-1:0] mem_addr_q,
  input wire logic [WORD_W-1:0] mem_wdata_q,
  input wire logic mem_resend_q,
  input wire logic mem_corr_q,
  output logic mem_done,
  output logic [WORD_W-1:0] mem_rdata,
  output logic mem_acpar_err,
  output logic mem_rdpar_err,
  input wire logic scan_tx_valid_q,
  input wire logic [SCAN_W-1:0] scan_tx_word_q,
  output logic rsp_in_valid,
  output logic [SCAN_W-1:0] rsp_in_word
);
  logic [WORD_W-1:0] mem_q [16];
  logic [SCAN_W-1:0] tx_q;
  logic [3:0] cnt_q, addr_q, scnt_q;
  logic [1:0] ac_q, rd_q;
  logic wr_q;
  always @(posedge clk) begin
    mem_done <= 1'b0;
    mem_acpar_err <= 1'b0;
    mem_rdpar_err <= 1'b0;
    rsp_in_valid <= 1'b0;
    // Released lines toggle so stale data never looks valid
    mem_rdata <= ~mem_rdata;
    rsp_in_word <= ~rsp_in_word;
    if (reset) begin
      cnt_q <= 4'h0;
      scnt_q <= 4'h0;
      ac_q <= 2'h0;
      rd_q <= 2'h0;
      mem_rdata <= '0;
      rsp_in_word <= '0;
    end else begin
      if (arm) begin
        ac_q <= ac_errs;
        rd_q <= rd_errs;
      end
      if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      if (mem_req_q || mem_resend_q || mem_corr_q) cnt_q <= 4'(LAT);
      if (mem_req_q) begin
        wr_q <= mem_write_q;
        addr_q <= mem_addr_q[3:0];
      end
      if (cnt_q == 4'h1) begin
        mem_done <= 1'b1;
        if (ac_q != 2'h0) begin
          mem_acpar_err <= 1'b1;
          ac_q <= ac_q - 2'h1;
        end else if (wr_q) begin
          mem_q[addr_q] <= mem_wdata_q;
        end else begin
          // Resend replays the latch, no new cycle
          mem_rdata <= mem_q[addr_q] ^ flip;
          if (rd_q != 2'h0) begin
            mem_rdpar_err <= 1'b1;
            rd_q <= rd_q - 2'h1;
          end
        end
      end
      if (scnt_q != 4'h0) scnt_q <= scnt_q - 4'h1;
      if (scan_tx_valid_q) begin
        scnt_q <= 4'h3;
        tx_q <= scan_tx_word_q;
      end
      if (scnt_q == 4'h1) begin
        rsp_in_valid <= 1'b1;
        rsp_in_word <= {tx_q[SCAN_W-1:4], 4'b1000};
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the exchange error and global scan block.
// Assumes mex_core and mex_far_model; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import mex_pkg::*;
;
  localparam logic [51:0] D1 = 52'h5_a5a5_1234_9876;
  localparam logic [18:0] GA = 19'h7fff3;
  localparam logic [47:0] SW = 48'h0412_3456_0042;
  localparam logic [47:0] SR = 48'h0412_3456_0048;
  logic clk, reset, req_valid, arm, msg_valid, msg_par_err;
  mex_req_t req;
  logic [1:0] ac_errs, rd_errs;
  logic [59:0] flip, wd;
  logic [47:0] msg_word, tx, sr;
  logic [4:0] msg_par_flags;
  logic [7:0] rx_state;
  logic [3:0] rx_flags;
  logic [51:0] dseen;
  logic [20:0] ga;
  logic ab, bz;
  logic req_ready_q, rsp_valid_q, rsp_abort_q, ev_single_q, ev_multi_q, ev_retry_q;
  logic ev_alarm_q, mem_req_q, mem_write_q, mem_global_q, mem_resend_q, mem_corr_q;
  logic mem_done, mem_acpar_err, mem_rdpar_err, scan_tx_valid_q, scan_bus_own_q;
  logic scan_busy_q, rsp_in_valid, msg_irq_q, resp_out_valid_q;
  logic [51:0] rsp_data_q;
  logic [47:0] scan_rdata_q, scan_tx_word_q, rsp_in_word, resp_out_word_q;
  logic [18:0] mem_addr_q;
  logic [59:0] mem_wdata_q, mem_rdata;
  int err_count, checked;
  int n [8];
  int b [8];
  logic [3:0] re [7] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h8, 4'h1, 4'h2};
  logic [59:0] rf [7] = '{60'h0, 60'h20, 60'h220, 60'h0, 60'h0, 60'h0, 60'h0};
  logic [31:0] rv [7] = '{32'h10000, 32'h10001, 32'h10010, 32'h20100, 32'h21000,
                          32'h110100, 32'h1110000};
  logic [5:0] opc [16] = '{6'h00, 6'h01, 6'h07, 6'h08, 6'h09, 6'h0e, 6'h0f, 6'h10,
                           6'h17, 6'h18, 6'h30, 6'h37, 6'h38, 6'h3b, 6'h3d, 6'h3e};
  logic [15:0] inv = 16'ha249;

  mex_core dut (.clk, .reset, .req_valid, .req, .req_ready_q, .rsp_valid_q, .rsp_data_q,
    .rsp_abort_q, .scan_rdata_q, .ev_single_q, .ev_multi_q, .ev_retry_q, .ev_alarm_q,
    .mem_req_q, .mem_write_q, .mem_global_q, .mem_addr_q, .mem_wdata_q, .mem_resend_q,
    .mem_corr_q, .mem_done, .mem_rdata, .mem_acpar_err, .mem_rdpar_err, .scan_tx_valid_q,
    .scan_tx_word_q, .scan_bus_own_q, .scan_busy_q, .rsp_in_valid, .rsp_in_word, .msg_valid,
    .msg_word, .msg_par_err, .msg_par_flags, .rx_state, .rx_flags, .msg_irq_q,
    .resp_out_valid_q, .resp_out_word_q);
  mex_far_model far (.clk, .reset, .arm, .ac_errs, .rd_errs, .flip, .mem_req_q,
    .mem_write_q, .mem_addr_q, .mem_wdata_q, .mem_resend_q, .mem_corr_q, .mem_done,
    .mem_rdata, .mem_acpar_err, .mem_rdpar_err, .scan_tx_valid_q, .scan_tx_word_q,
    .rsp_in_valid, .rsp_in_word);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulse counters let one compare cover every event of an operation
  always @(posedge clk) begin
    n[0] += ev_single_q;
    n[1] += ev_multi_q;
    n[2] += ev_retry_q;
    n[3] += ev_alarm_q;
    n[4] += mem_req_q;
    n[5] += mem_resend_q;
    n[6] += mem_corr_q;
    n[7] += msg_irq_q;
    if (mem_req_q) begin
      wd = mem_wdata_q;
      ga = {mem_write_q, mem_global_q, mem_addr_q};
    end
    if (scan_tx_valid_q) begin
      tx = scan_tx_word_q;
      bz = scan_busy_q & scan_bus_own_q;
    end
  end

  task automatic chk(input string nm, input logic [59:0] s, input logic [59:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic op(input logic [4:0] f, input logic [18:0] a, input logic [51:0] d,
                    input logic [3:0] er, input logic [59:0] fl, input logic [31:0] e);
    int k;
    logic [31:0] s;
    @(posedge clk);
    b = n;
    ac_errs <= er[3:2];
    rd_errs <= er[1:0];
    flip <= fl;
    arm <= 1'b1;
    req <= '{f[4], f[3], f[2], f[1], f[0], a, d};
    req_valid <= 1'b1;
    k = 0;
    do @(posedge clk); while (req_ready_q !== 1'b1 && ++k < 50);
    req_valid <= 1'b0;
    arm <= 1'b0;
    do @(posedge clk); while (rsp_valid_q !== 1'b1 && ++k < 200);
    chk("handshake", k < 200, 1'b1);
    dseen = rsp_data_q;
    ab = rsp_abort_q;
    sr = scan_rdata_q;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++) s[4*i+:4] = 4'(n[i] - b[i]);
    chk("events", s, e);
  endtask

  task automatic msg(input logic [47:0] w, input logic pe, input logic [47:0] e,
                     input logic ir);
    int k;
    @(posedge clk);
    b = n;
    msg_word <= w;
    msg_par_err <= pe;
    msg_valid <= 1'b1;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_word <= ~w;
    k = 0;
    do @(posedge clk); while (resp_out_valid_q !== 1'b1 && ++k < 5);
    chk("respvalid", k < 5, 1'b1);
    chk("respword", resp_out_word_q, e);
    repeat (2) @(posedge clk);
    chk("irq", 4'(n[7] - b[7]), ir);
  endtask

  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    complete_run();
  end

  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    arm = 1'b0;
    ac_errs = 2'h0;
    rd_errs = 2'h0;
    flip = '0;
    msg_valid = 1'b0;
    msg_word = '0;
    msg_par_err = 1'b0;
    msg_par_flags = 5'h15;
    rx_state = 8'ha5;
    rx_flags = 4'h9;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    op(5'b10100, GA, D1, 4'h0, '0, 32'h10000);
    chk("wdata", wd[51:0], D1);
    chk("wparity", {wd[59], ^wd[58:0]}, 2'b00);
    chk("gaddr", ga, {2'b11, GA});
    for (int i = 0; i < 7; i++) begin
      op(5'b10000, GA, '0, re[i], rf[i], rv[i]);
      chk("abort", ab, i == 4);
      if (i != 4) chk("rdata", dseen, i == 2 ? D1 ^ rf[i][51:0] : D1);
    end
    // Scan flag without the global port must stay a plain memory write
    op(5'b01100, GA, D1, 4'h4, '0, 32'h20100);
    chk("laddr", ga, {2'b10, GA});
    // Message buffer select (sel_msg) set on a scan-out must be ignored
    op(5'b11001, GA, {4'h0, SW}, 4'h0, '0, 32'h0);
    chk("txword", tx, SW);
    chk("busy", bz, 1'b1);
    chk("scanrsp", sr, SR);
    chk("release", {scan_busy_q, scan_bus_own_q}, 2'b00);
    op(5'b11010, GA, '0, 4'h0, '0, 32'h0);
    chk("scanin0", sr, SR);
    for (int i = 0; i < 16; i++) begin
      msg({opc[i], 42'h12_3456_789a}, 1'b0, 48'h9a58 | {inv[i], 1'b0}, 1'b1);
    end
    msg(SW, 1'b1, 48'h915d, 1'b0);
    msg(SW, 1'b0, 48'h9a58, 1'b1);
    op(5'b11011, GA, '0, 4'h0, '0, 32'h0);
    chk("scanin1", sr, SW);
    complete_run();
  end
endmodule
`default_nettype wire
